// *** hdl/pix_out_cfg_regs.sv ***
// register bank and pixel controls for the output and correction path
// assumes an AXI4-Lite master on MCLK_I and a calculated coefficient source
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module pix_out_cfg_regs
  import pix_out_cfg_pkg::*;
(
  input  wire logic                MCLK_I,
  input  wire logic                RESET_I,
  // axi4-lite slave
  input  wire logic [ADDR_W-1:0]   S_AXI_AWADDR_I,
  input  wire logic                S_AXI_AWVALID_I,
  output logic                     S_AXI_AWREADY_O,
  input  wire logic [31:0]         S_AXI_WDATA_I,
  input  wire logic [3:0]          S_AXI_WSTRB_I,
  input  wire logic                S_AXI_WVALID_I,
  output logic                     S_AXI_WREADY_O,
  output logic [1:0]               S_AXI_BRESP_O,
  output logic                     S_AXI_BVALID_O,
  input  wire logic                S_AXI_BREADY_I,
  input  wire logic [ADDR_W-1:0]   S_AXI_ARADDR_I,
  input  wire logic                S_AXI_ARVALID_I,
  output logic                     S_AXI_ARREADY_O,
  output logic [31:0]              S_AXI_RDATA_O,
  output logic [1:0]               S_AXI_RRESP_O,
  output logic                     S_AXI_RVALID_O,
  input  wire logic                S_AXI_RREADY_I,
  // calculated white balance coefficients
  input  wire logic [COEF_W-1:0]   CALC_COEF_RED_I,
  input  wire logic [COEF_W-1:0]   CALC_COEF_GREEN_I,
  input  wire logic [COEF_W-1:0]   CALC_COEF_BLUE_I,
  input  wire logic                CALC_COEF_VALID_I,
  output logic                     BALANCE_CALC_RUN_O,
  // pixel path
  input  wire logic [PIX_W-1:0]    PIX_DATA_I,
  input  wire logic [PIX_W-1:0]    LUT1_DATA_I,
  input  wire logic [PIX_W-1:0]    LUT2_DATA_I,
  output logic [PIX_W-1:0]         PIX_DATA_O,
  // decoded controls
  output logic                     TAP_DUAL_O,
  output logic                     TAP_CFG_ERR_O,
  output logic                     FMT_INTERLEAVED_O,
  output logic                     FMT_SEQUENTIAL_O,
  output logic                     FMT_CFG_ERR_O,
  output logic                     BALANCE_APPLY_O,
  output logic [COEF_W-1:0]        COEF_RED_O,
  output logic [COEF_W-1:0]        COEF_GREEN_O,
  output logic [COEF_W-1:0]        COEF_BLUE_O,
  output logic [COEF_W-1:0]        GAIN_RED_O,
  output logic [COEF_W-1:0]        GAIN_GREEN_O,
  output logic [COEF_W-1:0]        GAIN_BLUE_O,
  output logic [COEF_W-1:0]        OFFSET_RED_O,
  output logic [COEF_W-1:0]        OFFSET_GREEN_O,
  output logic [COEF_W-1:0]        OFFSET_BLUE_O,
  output logic                     DEFECT_FIX_STATIC_O,
  output logic                     DEFECT_FIX_DYNAMIC_O,
  output logic                     HOT_FIX_STATIC_O,
  output logic                     HOT_FIX_DYNAMIC_O,
  output logic                     FLAT_FIX_ENABLE_O
);

  // --------------------------------------------------------------------------
  // storage
  // --------------------------------------------------------------------------
  logic [3:0]        shift_reg;
  logic [1:0]        tap_count_reg;
  logic [2:0]        tap_format_reg;
  logic              lookup_table_select_reg;
  logic              lookup_table_enable_reg;
  logic [1:0]        defect_fix_reg;
  logic [1:0]        hot_fix_reg;
  logic              flat_fix_reg;
  logic              invert_reg;
  logic [1:0]        balance_mode_reg;
  logic [COEF_W-1:0] coef_reg   [3];
  logic [COEF_W-1:0] gain_reg   [3];
  logic [COEF_W-1:0] offset_reg [3];
  logic              once_done_reg;

  // --------------------------------------------------------------------------
  // write channel
  // --------------------------------------------------------------------------
  wr_state_e         wr_state_reg;
  logic              aw_held_reg;
  logic              w_held_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [31:0]       w_data_reg;
  logic [3:0]        w_strb_reg;
  logic              wr_fire;
  logic              wr_hit;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0]       wr_data;
  logic [3:0]        wr_strb;
  logic [1:0]        bresp_reg;

  assign S_AXI_AWREADY_O = (wr_state_reg == WR_IDLE) && !aw_held_reg;
  assign S_AXI_WREADY_O  = (wr_state_reg == WR_IDLE) && !w_held_reg;
  assign S_AXI_BVALID_O  = (wr_state_reg == WR_RESP);
  assign S_AXI_BRESP_O   = bresp_reg;

  always_comb begin
    wr_addr = aw_held_reg ? aw_addr_reg : S_AXI_AWADDR_I;
    wr_data = w_held_reg ? w_data_reg : S_AXI_WDATA_I;
    wr_strb = w_held_reg ? w_strb_reg : S_AXI_WSTRB_I;
    wr_fire = (wr_state_reg == WR_IDLE)
              && (aw_held_reg || S_AXI_AWVALID_I)
              && (w_held_reg || S_AXI_WVALID_I);
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      wr_state_reg <= WR_IDLE;
      aw_held_reg  <= 1'b0;
      w_held_reg   <= 1'b0;
      aw_addr_reg  <= '0;
      w_data_reg   <= '0;
      w_strb_reg   <= '0;
      bresp_reg    <= RESP_OKAY;
    end else begin
      unique case (wr_state_reg)
        WR_IDLE: begin
          if (wr_fire) begin
            aw_held_reg  <= 1'b0;
            w_held_reg   <= 1'b0;
            bresp_reg    <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            wr_state_reg <= WR_RESP;
          end else begin
            if (S_AXI_AWVALID_I && !aw_held_reg) begin
              aw_held_reg <= 1'b1;
              aw_addr_reg <= S_AXI_AWADDR_I;
            end
            if (S_AXI_WVALID_I && !w_held_reg) begin
              w_held_reg <= 1'b1;
              w_data_reg <= S_AXI_WDATA_I;
              w_strb_reg <= S_AXI_WSTRB_I;
            end
          end
        end
        WR_RESP: begin
          if (S_AXI_BREADY_I) begin
            wr_state_reg <= WR_HOLD;
          end
        end
        WR_HOLD: begin
          wr_state_reg <= WR_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // address decode
  // --------------------------------------------------------------------------
  function automatic logic known_addr(input logic [ADDR_W-1:0] a);
    unique case (a)
      OFS_BIT_SHIFT, OFS_TAP_COUNT, OFS_TAP_FORMAT, OFS_LOOKUP_TABLE_SELECT,
      OFS_LOOKUP_TABLE_ENABLE, OFS_DEFECT_FIX, OFS_HOT_FIX, OFS_FLAT_FIX,
      OFS_INVERT, OFS_BALANCE_MODE, OFS_COEF_RED, OFS_COEF_GREEN,
      OFS_COEF_BLUE, OFS_GAIN_RED, OFS_GAIN_GREEN, OFS_GAIN_BLUE,
      OFS_OFFSET_RED, OFS_OFFSET_GREEN, OFS_OFFSET_BLUE: known_addr = 1'b1;
      default: known_addr = 1'b0;
    endcase
  endfunction

  assign wr_hit = known_addr(wr_addr);

  logic wr_lo;
  logic wr_hi;
  assign wr_lo = wr_fire && wr_strb[0];
  assign wr_hi = wr_fire && wr_strb[1];

  // --------------------------------------------------------------------------
  // control registers
  // --------------------------------------------------------------------------
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      shift_reg      <= SHIFT_RESET;
      tap_count_reg  <= TAP_SINGLE;
      tap_format_reg <= FMT_ONE_OUTPUT;
      lookup_table_select_reg <= 1'b0;
      lookup_table_enable_reg <= 1'b0;
      defect_fix_reg <= 2'h0;
      hot_fix_reg    <= 2'h0;
      flat_fix_reg   <= 1'b0;
      invert_reg     <= 1'b0;
      balance_mode_reg <= BALANCE_OFF;
    end else if (wr_lo) begin
      // only the low field bits are kept
      unique case (wr_addr)
        OFS_BIT_SHIFT:  shift_reg      <= wr_data[3:0];
        OFS_TAP_COUNT:  tap_count_reg  <= wr_data[1:0];
        OFS_TAP_FORMAT: tap_format_reg <= wr_data[2:0];
        OFS_LOOKUP_TABLE_SELECT: lookup_table_select_reg <= wr_data[0];
        OFS_LOOKUP_TABLE_ENABLE: lookup_table_enable_reg <= wr_data[0];
        OFS_DEFECT_FIX: defect_fix_reg <= wr_data[1:0];
        OFS_HOT_FIX:    hot_fix_reg    <= wr_data[1:0];
        OFS_FLAT_FIX:   flat_fix_reg   <= wr_data[0];
        OFS_INVERT:     invert_reg     <= wr_data[0];
        OFS_BALANCE_MODE: balance_mode_reg <= wr_data[1:0];
        default: ;
      endcase
    end
  end

  logic calc_take;
  assign calc_take = CALC_COEF_VALID_I
                     && (balance_mode_reg == BALANCE_AUTO
                         || (balance_mode_reg == BALANCE_ONCE && !once_done_reg));

  // one-shot balance: one calculated set per write of the once mode
  // a take wins over a re-arm in the same cycle
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      once_done_reg <= 1'b0;
    end else if (calc_take && balance_mode_reg == BALANCE_ONCE) begin
      once_done_reg <= 1'b1;
    end else if (wr_lo && wr_addr == OFS_BALANCE_MODE) begin
      once_done_reg <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // per-channel coefficient, gain and offset
  // --------------------------------------------------------------------------
  logic [ADDR_W-1:0] coef_ofs   [3];
  logic [ADDR_W-1:0] gain_ofs   [3];
  logic [ADDR_W-1:0] offset_ofs [3];
  logic [COEF_W-1:0] calc_coef  [3];
  assign coef_ofs   = '{OFS_COEF_RED, OFS_COEF_GREEN, OFS_COEF_BLUE};
  assign gain_ofs   = '{OFS_GAIN_RED, OFS_GAIN_GREEN, OFS_GAIN_BLUE};
  assign offset_ofs = '{OFS_OFFSET_RED, OFS_OFFSET_GREEN, OFS_OFFSET_BLUE};
  assign calc_coef  = '{CALC_COEF_RED_I, CALC_COEF_GREEN_I, CALC_COEF_BLUE_I};

  // calculated value beats a software write
  for (genvar ch = 0; ch < 3; ch++) begin : g_chan
    always_ff @(posedge MCLK_I) begin
      if (RESET_I) begin
        coef_reg[ch] <= COEF_RESET;
      end else if (calc_take) begin
        coef_reg[ch] <= calc_coef[ch];
      end else if (balance_mode_reg == BALANCE_MANUAL && wr_addr == coef_ofs[ch]) begin
        if (wr_lo) coef_reg[ch][7:0] <= wr_data[7:0];
        if (wr_hi) coef_reg[ch][11:8] <= wr_data[11:8];
      end
    end

    always_ff @(posedge MCLK_I) begin
      if (RESET_I) begin
        gain_reg[ch]   <= COEF_RESET;
        offset_reg[ch] <= COEF_RESET;
      end else begin
        if (wr_addr == gain_ofs[ch]) begin
          if (wr_lo) gain_reg[ch][7:0] <= wr_data[7:0];
          if (wr_hi) gain_reg[ch][11:8] <= wr_data[11:8];
        end
        if (wr_addr == offset_ofs[ch]) begin
          if (wr_lo) offset_reg[ch][7:0] <= wr_data[7:0];
          if (wr_hi) offset_reg[ch][11:8] <= wr_data[11:8];
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // read channel
  // --------------------------------------------------------------------------
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  logic [31:0] rd_mux;

  assign S_AXI_ARREADY_O = !rvalid_reg;
  assign S_AXI_RVALID_O  = rvalid_reg;
  assign S_AXI_RDATA_O   = rdata_reg;
  assign S_AXI_RRESP_O   = rresp_reg;

  always_comb begin
    rd_mux = '0;
    unique case (S_AXI_ARADDR_I)
      OFS_BIT_SHIFT:    rd_mux[3:0]  = shift_reg;
      OFS_TAP_COUNT:    rd_mux[1:0]  = tap_count_reg;
      OFS_TAP_FORMAT:   rd_mux[2:0]  = tap_format_reg;
      OFS_LOOKUP_TABLE_SELECT:   rd_mux[0]    = lookup_table_select_reg;
      OFS_LOOKUP_TABLE_ENABLE:   rd_mux[0]    = lookup_table_enable_reg;
      OFS_DEFECT_FIX:   rd_mux[1:0]  = defect_fix_reg;
      OFS_HOT_FIX:      rd_mux[1:0]  = hot_fix_reg;
      OFS_FLAT_FIX:     rd_mux[0]    = flat_fix_reg;
      OFS_INVERT:       rd_mux[0]    = invert_reg;
      OFS_BALANCE_MODE: rd_mux[1:0]  = balance_mode_reg;
      OFS_COEF_RED:     rd_mux[11:0] = coef_reg[0];
      OFS_COEF_GREEN:   rd_mux[11:0] = coef_reg[1];
      OFS_COEF_BLUE:    rd_mux[11:0] = coef_reg[2];
      OFS_GAIN_RED:     rd_mux[11:0] = gain_reg[0];
      OFS_GAIN_GREEN:   rd_mux[11:0] = gain_reg[1];
      OFS_GAIN_BLUE:    rd_mux[11:0] = gain_reg[2];
      OFS_OFFSET_RED:   rd_mux[11:0] = offset_reg[0];
      OFS_OFFSET_GREEN: rd_mux[11:0] = offset_reg[1];
      OFS_OFFSET_BLUE:  rd_mux[11:0] = offset_reg[2];
      default: ;
    endcase
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= '0;
      rresp_reg  <= RESP_OKAY;
    end else if (rvalid_reg) begin
      if (S_AXI_RREADY_I) rvalid_reg <= 1'b0;
    end else if (S_AXI_ARVALID_I) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_mux;
      rresp_reg  <= known_addr(S_AXI_ARADDR_I) ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // --------------------------------------------------------------------------
  // pixel path: table, shift, invert
  // --------------------------------------------------------------------------
  logic [PIX_W-1:0] lut_out;
  logic [PIX_W-1:0] shifted;
  logic [PIX_W-1:0] pix_reg;

  always_comb begin
    lut_out = PIX_DATA_I;
    if (lookup_table_enable_reg) begin
      lut_out = lookup_table_select_reg ? LUT2_DATA_I : LUT1_DATA_I;
    end
    if (shift_reg[3] == 1'b0) begin
      shifted = lut_out << shift_reg[2:0];
    end else if (shift_reg == SHIFT_RESERVED) begin
      shifted = lut_out;
    end else begin
      shifted = lut_out >> shift_reg[2:0];
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      pix_reg <= '0;
    end else begin
      pix_reg <= invert_reg ? ~shifted : shifted;
    end
  end

  // --------------------------------------------------------------------------
  // decoded outputs
  // --------------------------------------------------------------------------
  assign PIX_DATA_O           = pix_reg;
  assign TAP_DUAL_O           = (tap_count_reg == TAP_DUAL);
  assign TAP_CFG_ERR_O        = tap_count_reg[1];
  assign FMT_INTERLEAVED_O    = (tap_format_reg == FMT_INTERLEAVED);
  assign FMT_SEQUENTIAL_O     = (tap_format_reg == FMT_SEQUENTIAL);
  assign FMT_CFG_ERR_O        = (tap_format_reg > FMT_SEQUENTIAL);
  assign BALANCE_APPLY_O      = (balance_mode_reg != BALANCE_OFF);
  assign BALANCE_CALC_RUN_O   = calc_take || (balance_mode_reg == BALANCE_AUTO);
  assign COEF_RED_O           = coef_reg[0];
  assign COEF_GREEN_O         = coef_reg[1];
  assign COEF_BLUE_O          = coef_reg[2];
  assign GAIN_RED_O           = gain_reg[0];
  assign GAIN_GREEN_O         = gain_reg[1];
  assign GAIN_BLUE_O          = gain_reg[2];
  assign OFFSET_RED_O         = offset_reg[0];
  assign OFFSET_GREEN_O       = offset_reg[1];
  assign OFFSET_BLUE_O        = offset_reg[2];
  assign DEFECT_FIX_STATIC_O  = defect_fix_reg[0];
  assign DEFECT_FIX_DYNAMIC_O = defect_fix_reg[1];
  assign HOT_FIX_STATIC_O     = hot_fix_reg[0];
  assign HOT_FIX_DYNAMIC_O    = hot_fix_reg[1];
  assign FLAT_FIX_ENABLE_O    = flat_fix_reg;

endmodule

// *** hdl/pix_out_cfg_pkg.sv ***
// constants for the pixel output configuration register bank
// assumes an AXI4-Lite master with 32-bit data and aligned word access
package pix_out_cfg_pkg;

  // --------------------------------------------------------------------------
  // register byte offsets
  // --------------------------------------------------------------------------
  localparam int          ADDR_W             = 12;
  localparam logic [11:0] OFS_BIT_SHIFT      = 12'h104;
  localparam logic [11:0] OFS_TAP_COUNT      = 12'h108;
  localparam logic [11:0] OFS_TAP_FORMAT     = 12'h10c;
  localparam logic [11:0] OFS_LOOKUP_TABLE_SELECT     = 12'h118;
  localparam logic [11:0] OFS_LOOKUP_TABLE_ENABLE     = 12'h11c;
  localparam logic [11:0] OFS_DEFECT_FIX     = 12'h120;
  localparam logic [11:0] OFS_HOT_FIX        = 12'h124;
  localparam logic [11:0] OFS_FLAT_FIX       = 12'h128;
  localparam logic [11:0] OFS_INVERT         = 12'h188;
  localparam logic [11:0] OFS_BALANCE_MODE   = 12'h300;
  localparam logic [11:0] OFS_COEF_RED       = 12'h304;
  localparam logic [11:0] OFS_COEF_GREEN     = 12'h308;
  localparam logic [11:0] OFS_COEF_BLUE      = 12'h30c;
  localparam logic [11:0] OFS_GAIN_RED       = 12'h310;
  localparam logic [11:0] OFS_GAIN_GREEN     = 12'h314;
  localparam logic [11:0] OFS_GAIN_BLUE      = 12'h318;
  localparam logic [11:0] OFS_OFFSET_RED     = 12'h31c;
  localparam logic [11:0] OFS_OFFSET_GREEN   = 12'h320;
  localparam logic [11:0] OFS_OFFSET_BLUE    = 12'h324;

  // --------------------------------------------------------------------------
  // field widths and reset values
  // --------------------------------------------------------------------------
  localparam int          COEF_W             = 12;
  localparam int          PIX_W              = 16;
  localparam logic [11:0] COEF_RESET         = 12'h000;
  localparam logic [3:0]  SHIFT_RESET        = 4'h0;
  localparam logic [1:0]  RESP_OKAY          = 2'h0;
  localparam logic [1:0]  RESP_SLVERR        = 2'h2;

  // --------------------------------------------------------------------------
  // field encodings
  // --------------------------------------------------------------------------
  localparam logic [1:0]  TAP_SINGLE         = 2'h0;
  localparam logic [1:0]  TAP_DUAL           = 2'h1;
  localparam logic [2:0]  FMT_ONE_OUTPUT     = 3'h0;
  localparam logic [2:0]  FMT_INTERLEAVED    = 3'h1;
  localparam logic [2:0]  FMT_SEQUENTIAL     = 3'h2;
  localparam logic [3:0]  SHIFT_RESERVED     = 4'h8;
  localparam logic [1:0]  BALANCE_OFF        = 2'h0;
  localparam logic [1:0]  BALANCE_ONCE       = 2'h1;
  localparam logic [1:0]  BALANCE_AUTO       = 2'h2;
  localparam logic [1:0]  BALANCE_MANUAL     = 2'h3;

  typedef enum logic [2:0] {
    WR_IDLE = 3'b001,
    WR_RESP = 3'b010,
    WR_HOLD = 3'b100
  } wr_state_e;

endpackage

// *** testbench/pix_out_cfg_properties.sv ***
// assertions on the pixel output configuration register bank
// assumes binding onto pix_out_cfg_regs; sees its ports only
`timescale 1ns/1ps
module pix_out_cfg_props
  import pix_out_cfg_pkg::*;
(
  input wire logic              MCLK_I,
  input wire logic              RESET_I,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
  input wire logic              S_AXI_AWVALID_I,
  input wire logic              S_AXI_AWREADY_O,
  input wire logic [31:0]       S_AXI_WDATA_I,
  input wire logic [3:0]        S_AXI_WSTRB_I,
  input wire logic              S_AXI_WVALID_I,
  input wire logic              S_AXI_WREADY_O,
  input wire logic              TAP_DUAL_O,
  input wire logic              TAP_CFG_ERR_O,
  input wire logic              FMT_INTERLEAVED_O,
  input wire logic              FMT_SEQUENTIAL_O,
  input wire logic              FMT_CFG_ERR_O,
  input wire logic              BALANCE_APPLY_O,
  input wire logic [COEF_W-1:0] GAIN_RED_O,
  input wire logic [COEF_W-1:0] OFFSET_BLUE_O,
  input wire logic              DEFECT_FIX_STATIC_O,
  input wire logic              DEFECT_FIX_DYNAMIC_O,
  input wire logic              HOT_FIX_STATIC_O,
  input wire logic              HOT_FIX_DYNAMIC_O,
  input wire logic              FLAT_FIX_ENABLE_O
);
  // --------------------------------------------------------------------------
  // write take and captured data
  // --------------------------------------------------------------------------
  logic        go;
  logic [11:0] a;
  logic [31:0] q;
  assign go = S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O
              && (S_AXI_WSTRB_I[1:0] == 2'b11);
  assign a = S_AXI_AWADDR_I;
  always_ff @(posedge MCLK_I) begin
    q <= S_AXI_WDATA_I;
  end
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (RESET_I);
  // --------------------------------------------------------------------------
  // decoded controls follow written fields
  // --------------------------------------------------------------------------
  property p_tap;
    go && a == OFS_TAP_COUNT |=> TAP_DUAL_O == (q[1:0] == TAP_DUAL) && TAP_CFG_ERR_O == q[1];
  endproperty
  a_tap: assert property (p_tap) else $error("tap decode wrong");
  property p_fmt;
    go && a == OFS_TAP_FORMAT |=> FMT_INTERLEAVED_O == (q[2:0] == FMT_INTERLEAVED)
      && FMT_SEQUENTIAL_O == (q[2:0] == FMT_SEQUENTIAL) && FMT_CFG_ERR_O == (q[2:0] > 3'h2);
  endproperty
  a_fmt: assert property (p_fmt) else $error("format decode wrong");
  property p_balance;
    go && a == OFS_BALANCE_MODE |=> BALANCE_APPLY_O == (q[1:0] != BALANCE_OFF);
  endproperty
  a_balance: assert property (p_balance) else $error("balance mode decode wrong");
  property p_gain;
    go && a == OFS_GAIN_RED |=> GAIN_RED_O == q[11:0];
  endproperty
  a_gain: assert property (p_gain) else $error("red gain wrong");
  property p_ofs;
    go && a == OFS_OFFSET_BLUE |=> OFFSET_BLUE_O == q[11:0];
  endproperty
  a_ofs: assert property (p_ofs) else $error("blue offset wrong");
  property p_defect;
    go && a == OFS_DEFECT_FIX |=> {DEFECT_FIX_DYNAMIC_O, DEFECT_FIX_STATIC_O} == q[1:0];
  endproperty
  a_defect: assert property (p_defect) else $error("defect fix decode wrong");
  property p_hot;
    go && a == OFS_HOT_FIX |=> {HOT_FIX_DYNAMIC_O, HOT_FIX_STATIC_O} == q[1:0];
  endproperty
  a_hot: assert property (p_hot) else $error("hot fix decode wrong");
  property p_flat;
    go && a == OFS_FLAT_FIX |=> FLAT_FIX_ENABLE_O == q[0] ##1 $stable(FLAT_FIX_ENABLE_O);
  endproperty
  a_flat: assert property (p_flat) else $error("flat field enable wrong");
endmodule

bind pix_out_cfg_regs pix_out_cfg_props pix_out_cfg_props_i (
  .MCLK_I(MCLK_I), .RESET_I(RESET_I), .S_AXI_AWADDR_I(S_AXI_AWADDR_I),
  .S_AXI_AWVALID_I(S_AXI_AWVALID_I), .S_AXI_AWREADY_O(S_AXI_AWREADY_O),
  .S_AXI_WDATA_I(S_AXI_WDATA_I), .S_AXI_WSTRB_I(S_AXI_WSTRB_I),
  .S_AXI_WVALID_I(S_AXI_WVALID_I), .S_AXI_WREADY_O(S_AXI_WREADY_O),
  .TAP_DUAL_O(TAP_DUAL_O), .TAP_CFG_ERR_O(TAP_CFG_ERR_O), .FMT_CFG_ERR_O(FMT_CFG_ERR_O),
  .FMT_INTERLEAVED_O(FMT_INTERLEAVED_O), .FMT_SEQUENTIAL_O(FMT_SEQUENTIAL_O),
  .BALANCE_APPLY_O(BALANCE_APPLY_O), .GAIN_RED_O(GAIN_RED_O), .OFFSET_BLUE_O(OFFSET_BLUE_O),
  .DEFECT_FIX_STATIC_O(DEFECT_FIX_STATIC_O), .DEFECT_FIX_DYNAMIC_O(DEFECT_FIX_DYNAMIC_O),
  .HOT_FIX_STATIC_O(HOT_FIX_STATIC_O), .HOT_FIX_DYNAMIC_O(HOT_FIX_DYNAMIC_O),
  .FLAT_FIX_ENABLE_O(FLAT_FIX_ENABLE_O));

// *** testbench/tb_top.sv ***
// self-checking bench for the pixel output configuration register bank
// assumes an AXI4-Lite slave on MCLK_I; ports mirror the design
`timescale 1ns/1ps
module tb_top
  import pix_out_cfg_pkg::*;
  ;
  logic MCLK_I = 1'b0, RESET_I = 1'b1, CALC_COEF_VALID_I = 1'b0, BALANCE_CALC_RUN_O;
  logic [ADDR_W-1:0] S_AXI_AWADDR_I = '0, S_AXI_ARADDR_I = '0;
  logic [31:0] S_AXI_WDATA_I = '0, S_AXI_RDATA_O;
  logic [3:0] S_AXI_WSTRB_I = '0;
  logic S_AXI_AWVALID_I = 0, S_AXI_WVALID_I = 0, S_AXI_BREADY_I = 0;
  logic S_AXI_ARVALID_I = 0, S_AXI_RREADY_I = 0, S_AXI_AWREADY_O, S_AXI_WREADY_O;
  logic S_AXI_BVALID_O, S_AXI_ARREADY_O, S_AXI_RVALID_O;
  logic [1:0] S_AXI_BRESP_O, S_AXI_RRESP_O;
  logic [COEF_W-1:0] CALC_COEF_RED_I = '0, CALC_COEF_GREEN_I = '0, CALC_COEF_BLUE_I = '0;
  logic [PIX_W-1:0] PIX_DATA_I = '0, LUT1_DATA_I = '0, LUT2_DATA_I = '0, PIX_DATA_O;
  logic TAP_DUAL_O, TAP_CFG_ERR_O, FMT_INTERLEAVED_O, FMT_SEQUENTIAL_O, FMT_CFG_ERR_O;
  logic BALANCE_APPLY_O, DEFECT_FIX_STATIC_O, DEFECT_FIX_DYNAMIC_O, HOT_FIX_STATIC_O;
  logic HOT_FIX_DYNAMIC_O, FLAT_FIX_ENABLE_O;
  logic [COEF_W-1:0] COEF_RED_O, COEF_GREEN_O, COEF_BLUE_O, GAIN_RED_O, GAIN_GREEN_O;
  logic [COEF_W-1:0] GAIN_BLUE_O, OFFSET_RED_O, OFFSET_GREEN_O, OFFSET_BLUE_O;
  int fails = 0, tests_run = 0, cycles = 0;
  localparam logic [11:0] OFS [19] = '{OFS_BIT_SHIFT, OFS_TAP_COUNT, OFS_TAP_FORMAT,
    OFS_LOOKUP_TABLE_SELECT, OFS_LOOKUP_TABLE_ENABLE, OFS_DEFECT_FIX, OFS_HOT_FIX, OFS_FLAT_FIX, OFS_INVERT,
    OFS_BALANCE_MODE, OFS_COEF_RED, OFS_COEF_GREEN, OFS_COEF_BLUE, OFS_GAIN_RED, OFS_GAIN_GREEN,
    OFS_GAIN_BLUE, OFS_OFFSET_RED, OFS_OFFSET_GREEN, OFS_OFFSET_BLUE};
  localparam logic [11:0] MSK [19] = '{12'h00f, 12'h003, 12'h007, 12'h001, 12'h001, 12'h003,
    12'h003, 12'h001, 12'h001, 12'h003, 12'hfff, 12'hfff, 12'hfff, 12'hfff, 12'hfff,
    12'hfff, 12'hfff, 12'hfff, 12'hfff};
  localparam logic [11:0] DOF [6] = '{OFS_TAP_COUNT, OFS_TAP_FORMAT, OFS_BALANCE_MODE,
    OFS_DEFECT_FIX, OFS_HOT_FIX, OFS_FLAT_FIX};
  localparam int DN [6] = '{4, 8, 4, 4, 4, 2};
  localparam logic [15:0] PIX = 16'h8f1d;

  pix_out_cfg_regs pix_out_cfg_regs_i (.*);

  always #2.5 MCLK_I = ~MCLK_I;
  always @(posedge MCLK_I) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      results();
    end
  end
  // --------------------------------------------------------------------------
  // bus and compare tasks
  // --------------------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic aw, w;
    @(posedge MCLK_I);
    S_AXI_AWADDR_I <= a;
    S_AXI_WDATA_I <= d;
    S_AXI_WSTRB_I <= s;
    S_AXI_AWVALID_I <= 1'b1;
    S_AXI_WVALID_I <= 1'b1;
    S_AXI_BREADY_I <= 1'b1;
    aw = 1'b1;
    w = 1'b1;
    while (aw || w) begin
      @(posedge MCLK_I);
      if (aw && S_AXI_AWREADY_O === 1'b1) begin
        aw = 1'b0;
        S_AXI_AWVALID_I <= 1'b0;
      end
      if (w && S_AXI_WREADY_O === 1'b1) begin
        w = 1'b0;
        S_AXI_WVALID_I <= 1'b0;
      end
    end
    while (S_AXI_BVALID_O !== 1'b1) @(posedge MCLK_I);
    chk("bresp", er, S_AXI_BRESP_O);
    S_AXI_BREADY_I <= 1'b0;
  endtask
  task automatic ww(input logic [11:0] a, input logic [31:0] d);
    wr(a, d, 4'hf, RESP_OKAY);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge MCLK_I);
    S_AXI_ARADDR_I <= a;
    S_AXI_ARVALID_I <= 1'b1;
    S_AXI_RREADY_I <= 1'b1;
    do @(posedge MCLK_I); while (S_AXI_ARREADY_O !== 1'b1);
    S_AXI_ARVALID_I <= 1'b0;
    do @(posedge MCLK_I); while (S_AXI_RVALID_O !== 1'b1);
    chk("rdata", e, S_AXI_RDATA_O);
    chk("rresp", er, S_AXI_RRESP_O);
    S_AXI_RREADY_I <= 1'b0;
  endtask
  task automatic calc(input logic [11:0] r, input logic [11:0] g, input logic [11:0] b);
    @(posedge MCLK_I);
    CALC_COEF_RED_I <= r;
    CALC_COEF_GREEN_I <= g;
    CALC_COEF_BLUE_I <= b;
    CALC_COEF_VALID_I <= 1'b1;
    @(posedge MCLK_I);
    CALC_COEF_VALID_I <= 1'b0;
  endtask
  task automatic pix(input string n, input logic [15:0] e);
    repeat (2) @(posedge MCLK_I);
    chk(n, e, PIX_DATA_O);
  endtask
  task results();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // --------------------------------------------------------------------------
  // test sequence
  // --------------------------------------------------------------------------
  initial begin
    repeat (8) @(posedge MCLK_I);
    RESET_I <= 1'b0;
    for (int i = 0; i < 19; i++) rd(OFS[i], 32'h0, RESP_OKAY);
    for (int i = 0; i < 19; i++) ww(OFS[i], 32'hffff_ffff);
    for (int i = 0; i < 19; i++) rd(OFS[i], {20'h0, MSK[i]}, RESP_OKAY);
    chk("coef red", 32'hfff, COEF_RED_O);
    chk("gain blue", 32'hfff, GAIN_BLUE_O);
    chk("offset green", 32'hfff, OFFSET_GREEN_O);
    chk("offset red", 32'hfff, OFFSET_RED_O);
    chk("coef green", 32'hfff, COEF_GREEN_O);
    wr(OFS_GAIN_GREEN, 32'h0, 4'h1, RESP_OKAY);
    chk("gain green", 32'hf00, GAIN_GREEN_O);
    ww(OFS_COEF_BLUE, 32'h0000_0abc);
    chk("coef blue", 32'habc, COEF_BLUE_O);
    wr(12'h000, 32'h1, 4'hf, RESP_SLVERR);
    rd(12'h000, 32'h0, RESP_SLVERR);
    for (int i = 0; i < 6; i++) begin
      for (int k = 0; k < DN[i]; k++) begin
        ww(DOF[i], k);
        rd(DOF[i], k, RESP_OKAY);
      end
    end
    ww(OFS_INVERT, 32'h0);
    ww(OFS_LOOKUP_TABLE_ENABLE, 32'h0);
    PIX_DATA_I <= PIX;
    LUT1_DATA_I <= 16'h1234;
    LUT2_DATA_I <= 16'hc3a5;
    for (int k = 0; k < 16; k++) begin
      ww(OFS_BIT_SHIFT, k);
      pix("pix shift", (k < 8) ? PIX << k : (k == 8) ? PIX : PIX >> (k - 8));
    end
    ww(OFS_BIT_SHIFT, 32'h0);
    ww(OFS_INVERT, 32'h1);
    pix("pix invert", 16'h70e2);
    ww(OFS_INVERT, 32'h0);
    ww(OFS_LOOKUP_TABLE_ENABLE, 32'h1);
    ww(OFS_LOOKUP_TABLE_SELECT, 32'h0);
    pix("pix table one", 16'h1234);
    ww(OFS_LOOKUP_TABLE_SELECT, 32'h1);
    pix("pix table two", 16'hc3a5);
    ww(OFS_LOOKUP_TABLE_ENABLE, 32'h0);
    pix("pix bypass", PIX);
    ww(OFS_BALANCE_MODE, BALANCE_ONCE);
    calc(12'h123, 12'h456, 12'h789);
    rd(OFS_COEF_RED, 32'h123, RESP_OKAY);
    calc(12'h321, 12'h654, 12'h987);
    rd(OFS_COEF_GREEN, 32'h456, RESP_OKAY);
    ww(OFS_BALANCE_MODE, BALANCE_AUTO);
    chk("calc run", 32'h1, BALANCE_CALC_RUN_O);
    calc(12'h0aa, 12'h0bb, 12'h0cc);
    rd(OFS_COEF_BLUE, 32'h0cc, RESP_OKAY);
    chk("coef blue auto", 32'h0cc, COEF_BLUE_O);
    ww(OFS_COEF_RED, 32'h5);
    rd(OFS_COEF_RED, 32'h0aa, RESP_OKAY);
    results();
  end
endmodule
